// ---- switch_i2c_config_read.sv ----
// sink configuration serial port with source select and output controls
// Operation
// - read begins with write of address and one sub-address byte, acked, then stop
// - address byte is 01011, then two strap bits, then direction bit
// - data phase restarts with same address, direction one, device acks first
// - device shifts one byte MSB first from the register chosen by the sub-address
// - with both supplies up, high output-enable-bar makes video outputs high-z
// - de-emphasis select high applies 3dB de-emphasis to video outputs
// - register low bits 00..11 choose source 1..4
// - only single-byte transfers; repeat whole sequence per register
`timescale 1ns/10ps
`include "switch_cfg_consts.svh"
module switch_i2c_config_read (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic link_clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic addr_strap_hi_in,
   input wire logic addr_strap_lo_in,
   input wire logic oe_n_in,
   input wire logic vcc_ok_in,
   input wire logic term_supply_ok_in,
   input wire logic deemph_sel_in,
   output logic video_hiz_out,
   output logic deemph_en_out,
   output logic sink1_select_lo_out,
   output logic sink1_select_hi_out,
   output logic sink2_select_lo_out,
   output logic sink2_select_hi_out,
   output logic [3:0] sink1_source_out,
   output logic [3:0] sink2_source_out,
   output logic dual_link_ok_out
);
   // link domain
   logic lrst_s1, lrst_reg;
   logic [3:0] lpin_s1, lpin_s2;
   logic scl_d, sda_d;
   switch_cfg_pkg::link_state_e state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next, tx_reg, tx_next;
   logic [7:0] regs_reg [0:3];
   logic [1:0] sub_reg, sub_next;
   logic rw_reg, rw_next, sda_oe_reg, oe_next, sda_low_reg, wr_en, upd_tgl_reg;

   wire scl_s = lpin_s2[3];
   wire sda_s = lpin_s2[2];
   wire [1:0] strap_s = lpin_s2[1:0];
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   // start and stop only while the clock stays high
   wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_seen = scl_s & scl_d & ~sda_d & sda_s;
   wire byte_done = cnt_reg == `CFG_BITS_PER_BYTE;
   wire addr_match = (shift_reg[7:3] == `CFG_DEV_PATTERN) && (shift_reg[2:1] == strap_s);
   wire [7:0] sel_byte = regs_reg[sub_reg];

   always_ff @(posedge link_clk_in)
   begin
      lrst_s1 <= rst_in;
      lrst_reg <= lrst_s1;
      lpin_s1 <= {scl_in, sda_in, addr_strap_hi_in, addr_strap_lo_in};
      lpin_s2 <= lpin_s1;
      scl_d <= lpin_s2[3];
      sda_d <= lpin_s2[2];
   end

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      tx_next = tx_reg;
      oe_next = sda_oe_reg;
      rw_next = rw_reg;
      sub_next = sub_reg;
      wr_en = 1'b0;
      if (start_seen)
      begin
         state_next = switch_cfg_pkg::st_addr;
         cnt_next = `CFG_CNT_RST;
         oe_next = 1'b0;
      end
      else if (stop_seen)
      begin
         state_next = switch_cfg_pkg::st_idle;
         oe_next = 1'b0;
      end
      else
      begin
         case (state_reg)
            switch_cfg_pkg::st_addr, switch_cfg_pkg::st_sub, switch_cfg_pkg::st_wdata:
            begin
               if (scl_rise)
               begin
                  shift_next = {shift_reg[6:0], sda_s};
                  cnt_next = cnt_reg + `CFG_CNT_STEP;
               end
               else if (scl_fall && byte_done)
               begin
                  cnt_next = `CFG_CNT_RST;
                  oe_next = 1'b1;
                  if (state_reg == switch_cfg_pkg::st_addr)
                  begin
                     if (addr_match)
                     begin
                        state_next = switch_cfg_pkg::st_ack_addr;
                        rw_next = shift_reg[0];
                     end
                     else
                     begin
                        state_next = switch_cfg_pkg::st_idle;
                        oe_next = 1'b0;
                     end
                  end
                  else if (state_reg == switch_cfg_pkg::st_sub)
                  begin
                     // upper bits are the master's duty; only the index is kept
                     state_next = switch_cfg_pkg::st_ack_sub;
                     sub_next = shift_reg[1:0];
                  end
                  else
                  begin
                     state_next = switch_cfg_pkg::st_ack_wdata;
                     wr_en = 1'b1;
                  end
               end
            end
            switch_cfg_pkg::st_ack_addr:
            begin
               if (scl_fall && rw_reg)
               begin
                  state_next = switch_cfg_pkg::st_rdata;
                  tx_next = sel_byte;
                  oe_next = ~sel_byte[7];
               end
               else if (scl_fall)
               begin
                  state_next = switch_cfg_pkg::st_sub;
                  oe_next = 1'b0;
               end
            end
            switch_cfg_pkg::st_ack_sub:
            begin
               if (scl_fall)
               begin
                  state_next = switch_cfg_pkg::st_wdata;
                  oe_next = 1'b0;
               end
            end
            switch_cfg_pkg::st_ack_wdata:
            begin
               if (scl_fall)
               begin
                  state_next = switch_cfg_pkg::st_idle;
                  oe_next = 1'b0;
               end
            end
            switch_cfg_pkg::st_rdata:
            begin
               if (scl_rise)
                  cnt_next = cnt_reg + `CFG_CNT_STEP;
               else if (scl_fall && byte_done)
               begin
                  // master's ack bit is not watched: one byte only
                  state_next = switch_cfg_pkg::st_idle;
                  oe_next = 1'b0;
               end
               else if (scl_fall)
               begin
                  tx_next = {tx_reg[6:0], 1'b0};
                  oe_next = ~tx_reg[6];
               end
            end
            default:
               state_next = switch_cfg_pkg::st_idle;
         endcase
      end
   end

   always_ff @(posedge link_clk_in)
   begin
      if (lrst_reg)
      begin
         state_reg <= switch_cfg_pkg::st_idle;
         cnt_reg <= `CFG_CNT_RST;
         shift_reg <= `CFG_REG_RST;
         tx_reg <= `CFG_REG_RST;
         sda_oe_reg <= 1'b0;
         rw_reg <= 1'b0;
         sub_reg <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         tx_reg <= tx_next;
         sda_oe_reg <= oe_next;
         rw_reg <= rw_next;
         sub_reg <= sub_next;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_reg
         always_ff @(posedge link_clk_in)
         begin
            if (lrst_reg)
               regs_reg[gi] <= `CFG_REG_RST;
            else if (wr_en && sub_reg == 2'(gi))
               regs_reg[gi] <= shift_reg;
         end
      end
   endgenerate

   always_ff @(posedge link_clk_in)
   begin
      sda_low_reg <= 1'b0;
      if (lrst_reg)
         upd_tgl_reg <= 1'b0;
      else if (wr_en)
         upd_tgl_reg <= ~upd_tgl_reg;
   end

   assign sda_out = sda_low_reg;
   assign sda_oe_out = sda_oe_reg;

   // system domain; register bytes are stable for a whole bus byte after the toggle
   logic [3:0] pin_s1, pin_s2;
   logic tgl_s1, tgl_s2, tgl_d;
   logic hiz_reg, deemph_reg, dual_reg;
   logic [1:0] sel1_reg, sel2_reg;
   logic [3:0] src1_reg, src2_reg;
   wire [1:0] sel1_next = regs_reg[`CFG_SINK1_IDX][1:0];
   wire [1:0] sel2_next = regs_reg[`CFG_SINK2_IDX][1:0];
   wire upd_seen = tgl_s2 ^ tgl_d;
   wire dual_next = ~sel1_next[0] & sel2_next[0] & (sel1_next[1] == sel2_next[1]);

   always_ff @(posedge sys_clk_in)
   begin
      pin_s1 <= {oe_n_in, vcc_ok_in, term_supply_ok_in, deemph_sel_in};
      pin_s2 <= pin_s1;
      tgl_s1 <= upd_tgl_reg;
      tgl_s2 <= tgl_s1;
      tgl_d <= tgl_s2;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         hiz_reg <= 1'b1;
         deemph_reg <= 1'b0;
      end
      else
      begin
         hiz_reg <= pin_s2[3] & pin_s2[2] & pin_s2[1];
         deemph_reg <= pin_s2[0];
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         sel1_reg <= 2'h0;
         sel2_reg <= 2'h0;
         src1_reg <= `CFG_SRC_ONEHOT;
         src2_reg <= `CFG_SRC_ONEHOT;
         dual_reg <= 1'b0;
      end
      else if (upd_seen)
      begin
         sel1_reg <= sel1_next;
         sel2_reg <= sel2_next;
         src1_reg <= `CFG_SRC_ONEHOT << sel1_next;
         src2_reg <= `CFG_SRC_ONEHOT << sel2_next;
         dual_reg <= dual_next;
      end
   end

   assign video_hiz_out = hiz_reg;
   assign deemph_en_out = deemph_reg;
   assign sink1_select_lo_out = sel1_reg[0];
   assign sink1_select_hi_out = sel1_reg[1];
   assign sink2_select_lo_out = sel2_reg[0];
   assign sink2_select_hi_out = sel2_reg[1];
   assign sink1_source_out = src1_reg;
   assign sink2_source_out = src2_reg;
   assign dual_link_ok_out = dual_reg;

   property p_ack_addr;
      @(posedge link_clk_in) disable iff (lrst_reg)
      state_reg == switch_cfg_pkg::st_ack_addr |-> sda_oe_reg && addr_match;
   endproperty
   a_ack_addr: assert property (p_ack_addr) else $error("address ack without match");

   property p_no_ack;
      @(posedge link_clk_in) disable iff (lrst_reg)
      (state_reg == switch_cfg_pkg::st_addr && scl_fall && byte_done && !addr_match
         && !start_seen && !stop_seen) |=> !sda_oe_reg && state_reg == switch_cfg_pkg::st_idle;
   endproperty
   a_no_ack: assert property (p_no_ack) else $error("foreign address acked");

   property p_sub_ack;
      @(posedge link_clk_in) disable iff (lrst_reg)
      $rose(state_reg == switch_cfg_pkg::st_ack_sub) |-> sda_oe_reg && sub_reg == shift_reg[1:0];
   endproperty
   a_sub_ack: assert property (p_sub_ack) else $error("sub-address not taken");

   property p_read_start;
      @(posedge link_clk_in) disable iff (lrst_reg)
      (state_reg == switch_cfg_pkg::st_ack_addr && rw_reg && scl_fall && !start_seen
         && !stop_seen) |=> state_reg == switch_cfg_pkg::st_rdata;
   endproperty
   a_read_start: assert property (p_read_start) else $error("read not started after ack");

   property p_first_bit;
      @(posedge link_clk_in) disable iff (lrst_reg)
      $rose(state_reg == switch_cfg_pkg::st_rdata) |-> sda_oe_reg == !sel_byte[7];
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("wrong first data bit");

   property p_single_byte;
      @(posedge link_clk_in) disable iff (lrst_reg)
      (state_reg == switch_cfg_pkg::st_rdata && scl_fall && byte_done)
         |=> !sda_oe_reg && state_reg != switch_cfg_pkg::st_rdata;
   endproperty
   a_single_byte: assert property (p_single_byte) else $error("more than one byte sent");

   property p_hiz;
      @(posedge sys_clk_in) disable iff (rst_in)
      (vcc_ok_in && term_supply_ok_in && oe_n_in)[*5] |-> video_hiz_out;
   endproperty
   a_hiz: assert property (p_hiz) else $error("outputs not high-z");

   property p_deemph;
      @(posedge sys_clk_in) disable iff (rst_in)
      (deemph_sel_in)[*5] |-> deemph_en_out;
   endproperty
   a_deemph: assert property (p_deemph) else $error("de-emphasis not applied");

   property p_source;
      @(posedge sys_clk_in) disable iff (rst_in)
      $onehot(sink1_source_out) && sink1_source_out[{sink1_select_hi_out, sink1_select_lo_out}];
   endproperty
   a_source: assert property (p_source) else $error("source decode mismatch");

   property p_dual;
      @(posedge sys_clk_in) disable iff (rst_in)
      dual_link_ok_out == (!sink1_select_lo_out && sink2_select_lo_out
         && sink1_select_hi_out == sink2_select_hi_out);
   endproperty
   a_dual: assert property (p_dual) else $error("dual-link flag mismatch");
endmodule

// ---- switch_cfg_consts.svh ----
// constants for the sink configuration serial port
`ifndef SWITCH_CFG_CONSTS_SVH
`define SWITCH_CFG_CONSTS_SVH
`define CFG_DEV_PATTERN 5'h0B
`define CFG_BITS_PER_BYTE 4'h8
`define CFG_CNT_RST 4'h0
`define CFG_CNT_STEP 4'h1
`define CFG_REG_RST 8'h00
`define CFG_SINK1_IDX 2'h1
`define CFG_SINK2_IDX 2'h2
`define CFG_SRC_ONEHOT 4'h1
`endif

// ---- switch_cfg_pkg.sv ----
// types for the sink configuration serial port
package switch_cfg_pkg;
   typedef enum logic [3:0] {
      st_idle = 4'h0,
      st_addr = 4'h1,
      st_ack_addr = 4'h2,
      st_sub = 4'h3,
      st_ack_sub = 4'h4,
      st_wdata = 4'h5,
      st_ack_wdata = 4'h6,
      st_rdata = 4'h7
   } link_state_e;
endpackage

// ---- cfg_bus_master.sv ----
// two-wire bus master model that talks to the configuration port
`timescale 1ns/10ps
module cfg_bus_master (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // six link cycles per half period, above the five the slave needs
   task automatic half();
      repeat (6) @(posedge clk_in);
   endtask
   task automatic start();
      sda_out <= 1'b0;
      half();
      scl_out <= 1'b0;
      half();
   endtask
   task automatic stop();
      sda_out <= 1'b0;
      half();
      scl_out <= 1'b1;
      half();
      sda_out <= 1'b1;
      half();
   endtask
   // data moves two cycles after the fall so it never reads as start or stop
   task automatic bit_x(input logic b, output logic r);
      sda_out <= b;
      half();
      scl_out <= 1'b1;
      half();
      r = sda_in;
      scl_out <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask
   // eight bits msb first, then a released ninth bit: slave ack or our not-ack
   task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r[i]);
      bit_x(1'b1, a);
   endtask
endmodule

// ---- tb_switch_i2c_config_read.sv ----
// self-checking bench for the sink configuration serial port
`timescale 1ns/10ps
`include "switch_cfg_consts.svh"
module tb_switch_i2c_config_read;
   logic sys_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] straps = 2'h0;
   logic oe_n = 1'b0, vcc_ok = 1'b1, term_ok = 1'b1, deemph = 1'b0;
   logic scl, sda_m, sda_o, sda_oe, hiz, de_en, s1lo, s1hi, s2lo, s2hi, dual;
   logic [3:0] src1, src2;
   int n_errors = 0;
   int checks_done = 0;
   // pull-up: the line sits high unless someone pulls it low
   wire sda_line = sda_m & ~(sda_oe & ~sda_o);
   always #10 sys_clk = ~sys_clk;
   always #62.5 link_clk = ~link_clk;
   cfg_bus_master u_master (.clk_in(link_clk), .sda_in(sda_line), .scl_out(scl),
      .sda_out(sda_m));
   switch_i2c_config_read u_dut (.sys_clk_in(sys_clk), .rst_in(rst), .link_clk_in(link_clk),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_out(sda_oe),
      .addr_strap_hi_in(straps[1]), .addr_strap_lo_in(straps[0]), .oe_n_in(oe_n),
      .vcc_ok_in(vcc_ok), .term_supply_ok_in(term_ok), .deemph_sel_in(deemph),
      .video_hiz_out(hiz), .deemph_en_out(de_en), .sink1_select_lo_out(s1lo),
      .sink1_select_hi_out(s1hi), .sink2_select_lo_out(s2lo), .sink2_select_hi_out(s2hi),
      .sink1_source_out(src1), .sink2_source_out(src2), .dual_link_ok_out(dual));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [1:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic a0, a1, a2;
      u_master.start();
      u_master.xfer({`CFG_DEV_PATTERN, straps, 1'b0}, r, a0);
      u_master.xfer({6'h00, idx}, r, a1);
      u_master.xfer(d, r, a2);
      u_master.stop();
      check("write acks", {5'h00, a0, a1, a2}, 8'h00);
   endtask
   task automatic rd(input logic [1:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      logic a0, a1, a2, a3;
      u_master.start();
      u_master.xfer({`CFG_DEV_PATTERN, straps, 1'b0}, r, a0);
      u_master.xfer({6'h00, idx}, r, a1);
      u_master.stop();
      u_master.start();
      u_master.xfer({`CFG_DEV_PATTERN, straps, 1'b1}, r, a2);
      u_master.xfer(8'hFF, r, a3);
      u_master.stop();
      check("read acks", {4'h0, a0, a1, a2, a3}, 8'h01);
      check("read data", r, exp);
   endtask
   task automatic pins(input logic [3:0] v);
      @(posedge sys_clk);
      {deemph, term_ok, vcc_ok, oe_n} <= v;
      repeat (5) @(posedge sys_clk);
      #1;
      check("video hiz", {7'h00, hiz}, {7'h00, &v[2:0]});
      check("deemphasis", {7'h00, de_en}, {7'h00, v[3]});
   endtask
   initial
   begin
      logic [7:0] r;
      logic a;
      // link side sees reset two link edges late; let its flops settle first
      repeat (4) @(posedge link_clk);
      #1;
      check("reset sources", {src1, src2}, 8'h11);
      check("reset flags", {hiz, de_en, s1lo, s1hi, s2lo, s2hi, dual, sda_oe}, 8'h80);
      @(posedge sys_clk);
      rst <= 1'b0;
      repeat (8) @(posedge link_clk);
      $display("test reset done");
      for (int i = 0; i < 16; i++)
         pins(i[3:0]);
      $display("test pins done");
      for (int c = 0; c < 4; c++)
      begin
         wr(2'h1, {6'h28, c[1:0]});
         check("sink1 source", {4'h0, src1}, 8'h01 << c);
         check("sink1 select", {6'h00, s1hi, s1lo}, {6'h00, c[1:0]});
         rd(2'h1, {6'h28, c[1:0]});
      end
      $display("test source codes done");
      wr(2'h1, 8'h02);
      wr(2'h2, 8'h03);
      check("sink2 select", {6'h00, s2hi, s2lo}, 8'h03);
      check("sink2 source", {4'h0, src2}, 8'h08);
      check("dual ok", {7'h00, dual}, 8'h01);
      wr(2'h2, 8'h01);
      check("dual bad", {7'h00, dual}, 8'h00);
      $display("test dual link done");
      wr(2'h0, 8'hA5);
      wr(2'h3, 8'h3C);
      rd(2'h0, 8'hA5);
      rd(2'h3, 8'h3C);
      rd(2'h2, 8'h01);
      $display("test storage done");
      for (int k = 0; k < 2; k++)
      begin
         u_master.start();
         u_master.xfer(k ? {5'h0A, straps, 1'b0} : {`CFG_DEV_PATTERN, ~straps, 1'b0}, r, a);
         u_master.stop();
         check("foreign address ack", {7'h00, a}, 8'h01);
      end
      @(posedge sys_clk);
      straps <= 2'h2;
      repeat (8) @(posedge link_clk);
      wr(2'h1, 8'h07);
      check("strapped source", {4'h0, src1}, 8'h08);
      rd(2'h1, 8'h07);
      $display("test straps done");
      end_of_test();
   end
   initial
   begin
      #2000000;
      n_errors++;
      $display("ERROR watchdog expected finish seen timeout");
      end_of_test();
   end
endmodule
